// ### include/srgd_pkg.sv
// Constants and types of the serial rate, gap and status block
// Assumes a 32-bit AXI4-Lite bus and one system clock
package srgd_pkg;
    // ---------------------------------------------
    // Register bus
    // ---------------------------------------------
    localparam int unsigned AXI_AW = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GAP_CTRL = 8'hf3;
    localparam logic [7:0] IDX_STATUS = 8'hf4;
    localparam logic [7:0] IDX_DATA = 8'hf5;
    localparam logic [7:0] IDX_CTRL = 8'hf6;
    localparam logic [7:0] IDX_IRQ_EN = 8'hf7;
    localparam logic [AXI_AW-1:0] ADDR_GAP_CTRL = {2'h0, IDX_GAP_CTRL, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_EN, 2'h0};
    // ---------------------------------------------
    // Reset values
    // ---------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GAP_CTRL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;
    // ---------------------------------------------
    // Field positions
    // ---------------------------------------------
    // serial_control
    localparam int CTL_SELECT_OUTPUT_ENABLE = 7;
    localparam int CTL_EN = 6;
    localparam int CTL_LSBF = 5;
    localparam int CTL_ROLE = 4;
    localparam int CTL_CLOCK_POLARITY_SELECT = 3;
    localparam int CTL_CLOCK_PHASE_SELECT = 2;
    localparam int CTL_DIV_MSB = 1;
    localparam int CTL_DIV_LSB = 0;
    // byte_gap_control
    localparam int GAP_MSB = 1;
    localparam int GAP_LSB = 0;
    // serial_status
    localparam int STS_DONE = 7;
    localparam int STS_WRITE_COLLISION_FLAG = 6;
    localparam int STS_OVF = 5;
    localparam int STS_FAULT = 4;
    localparam int STS_FDDIS = 3;
    // irq enables
    localparam int IRQ_BLOCK = 0;
    localparam int IRQ_GLOBAL = 1;
    // ---------------------------------------------
    // Transfer counts
    // ---------------------------------------------
    localparam logic [3:0] FIRST_EDGE = 4'h0;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [3:0] SYNC_RST = 4'h1;
    typedef enum {M_IDLE, M_SHIFT} srgd_mstate_e;
endpackage

// ### logic/srgd_sync.sv
// Two-stage synchroniser for pin inputs
// Assumes inputs are asynchronous to ref_clk_i
`timescale 1ns/1ps
module srgd_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ### logic/srgd_half_tick.sv
// Half-period tick of the master serial clock
// Assumes run_i and div_sel_i come from ref_clk_i logic
`timescale 1ns/1ps
module srgd_half_tick #(
    parameter int CW = 3
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic run_i,
    input wire logic [1:0] div_sel_i,
    // Tick
    output logic tick_o
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] top_w;

    // Half period of 1, 2, 4 or 8 cycles
    assign top_w = CW'((4'h1 << div_sel_i) - 4'h1);
    assign tick_o = run_i && (cnt_r == top_w);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_r <= '0;
        end else if (cnt_r == top_w) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule

// ### logic/srgd_top.sv
// Byte SPI controller, master or slave, with AXI4-Lite registers
// Assumes pins are asynchronous and a synchronous active-low reset
`timescale 1ns/1ps
module srgd_top
    import srgd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Serial pins
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe_o,
    // Interrupt
    output logic irq_o
);
    // ---------------------------------------------
    // Declarations
    // ---------------------------------------------
    logic [7:0] ctrl_r, wdata_r, tx_sh_r, tx_nxt, rx_sh_r, rx_buf_r, rx_in_w, rd_byte_w;
    logic [1:0] gap_sel_r, irq_en_r, div_w;
    logic transfer_done_flag_r, write_collision_flag_r, ovf_r, role_fault_flag_r, fault_detect_disable_r;
    logic aw_hold_r, w_hold_r, wstb_r, aw_take_w, w_take_w, ar_take_w, wr_do_w, rd_ok_w;
    logic [AXI_AW-1:0] awaddr_r;
    logic wr_hit_w, wr_data_w, stat_wr_w, data_acc_w, write_collision_flag_set_w, busy_w;
    logic select_output_enable_w, en_w, lsbf_w, role_w, clock_polarity_select_w, clock_phase_select_w;
    logic master_act_w, slave_sel_w, fault_w, tick_w, m_edge_w, s_edge_w, sh_edge_w;
    logic sample_w, done_w, din_w, tx_bit_nxt;
    logic sclk_s, mosi_s, miso_s, ss_n_s, sclk_prev_r, lead_r, pend_r;
    logic [3:0] edge_idx_r;
    logic [2:0] gap_cnt_r;
    srgd_mstate_e m_st_r;

    assign select_output_enable_w = ctrl_r[CTL_SELECT_OUTPUT_ENABLE];
    assign en_w = ctrl_r[CTL_EN];
    assign lsbf_w = ctrl_r[CTL_LSBF];
    assign role_w = ctrl_r[CTL_ROLE];
    assign clock_polarity_select_w = ctrl_r[CTL_CLOCK_POLARITY_SELECT];
    assign clock_phase_select_w = ctrl_r[CTL_CLOCK_PHASE_SELECT];
    assign div_w = ctrl_r[CTL_DIV_MSB:CTL_DIV_LSB];

    // ---------------------------------------------
    // Pin synchroniser and clock divider
    // ---------------------------------------------
    srgd_sync #(.W(4), .RST_VAL(SYNC_RST)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({sclk_i, mosi_i, miso_i, ss_n_i}),
        .q_o({sclk_s, mosi_s, miso_s, ss_n_s})
    );

    srgd_half_tick #(.CW(3)) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(master_act_w && (m_st_r == M_SHIFT || gap_cnt_r != 3'h0)),
        .div_sel_i(div_w),
        .tick_o(tick_w)
    );

    // ---------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------
    assign aw_take_w = awvalid_i && awready_o;
    assign w_take_w = wvalid_i && wready_o;
    assign ar_take_w = arvalid_i && arready_o;
    assign wr_do_w = aw_hold_r && w_hold_r && !bvalid_o;
    assign wr_hit_w = wr_do_w && wstb_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready_o <= 1'b0;
            wready_o <= 1'b0;
            bvalid_o <= 1'b0;
            bresp_o <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstb_r <= 1'b0;
        end else begin
            aw_hold_r <= (aw_hold_r || aw_take_w) && !wr_do_w;
            w_hold_r <= (w_hold_r || w_take_w) && !wr_do_w;
            awready_o <= !(aw_hold_r || aw_take_w || bvalid_o);
            wready_o <= !(w_hold_r || w_take_w || bvalid_o);
            bvalid_o <= wr_do_w || (bvalid_o && !bready_i);
            if (aw_take_w) awaddr_r <= awaddr_i;
            if (w_take_w) begin
                wdata_r <= wdata_i[7:0];
                wstb_r <= wstrb_i[0];
            end
            if (wr_do_w) begin
                bresp_o <= (awaddr_r == ADDR_CTRL || awaddr_r == ADDR_GAP_CTRL ||
                    awaddr_r == ADDR_STATUS || awaddr_r == ADDR_DATA ||
                    awaddr_r == ADDR_IRQ_EN) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_comb begin
        rd_ok_w = 1'b1;
        case (araddr_i)
            ADDR_CTRL: rd_byte_w = ctrl_r;
            ADDR_GAP_CTRL: rd_byte_w = {6'h00, gap_sel_r};
            ADDR_STATUS: rd_byte_w = {transfer_done_flag_r, write_collision_flag_r, ovf_r, role_fault_flag_r, fault_detect_disable_r, 3'h0};
            ADDR_DATA: rd_byte_w = rx_buf_r;
            ADDR_IRQ_EN: rd_byte_w = {6'h00, irq_en_r};
            default: begin
                rd_byte_w = 8'h00;
                rd_ok_w = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= RESP_OKAY;
        end else begin
            arready_o <= !(ar_take_w || rvalid_o);
            rvalid_o <= ar_take_w || (rvalid_o && !rready_i);
            if (ar_take_w) begin
                rdata_o <= {24'h00_0000, rd_byte_w};
                rresp_o <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ---------------------------------------------
    // Control registers
    // ---------------------------------------------
    assign fault_w = master_act_w && !fault_detect_disable_r && !ss_n_s;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
            gap_sel_r <= GAP_CTRL_RST[GAP_MSB:GAP_LSB];
            irq_en_r <= IRQ_EN_RST;
        end else begin
            if (wr_hit_w && awaddr_r == ADDR_CTRL) ctrl_r <= wdata_r;
            if (wr_hit_w && awaddr_r == ADDR_GAP_CTRL) gap_sel_r <= wdata_r[GAP_MSB:GAP_LSB];
            if (wr_hit_w && awaddr_r == ADDR_IRQ_EN) irq_en_r <= wdata_r[1:0];
            if (fault_w) begin
                ctrl_r[CTL_ROLE] <= 1'b0;
                ctrl_r[CTL_EN] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // Status flags
    // ---------------------------------------------
    assign stat_wr_w = wr_hit_w && awaddr_r == ADDR_STATUS;
    assign wr_data_w = wr_hit_w && awaddr_r == ADDR_DATA;
    assign master_act_w = en_w && role_w;
    assign slave_sel_w = en_w && !role_w && !ss_n_s;
    assign busy_w = role_w ? (m_st_r == M_SHIFT || pend_r) : slave_sel_w;
    assign data_acc_w = wr_data_w && !transfer_done_flag_r && !busy_w;
    assign write_collision_flag_set_w = wr_data_w && !transfer_done_flag_r && busy_w;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            transfer_done_flag_r <= STATUS_RST[STS_DONE];
            write_collision_flag_r <= STATUS_RST[STS_WRITE_COLLISION_FLAG];
            ovf_r <= STATUS_RST[STS_OVF];
            role_fault_flag_r <= STATUS_RST[STS_FAULT];
            fault_detect_disable_r <= STATUS_RST[STS_FDDIS];
        end else begin
            transfer_done_flag_r <= done_w || (transfer_done_flag_r && !(stat_wr_w && !wdata_r[STS_DONE]));
            write_collision_flag_r <= write_collision_flag_set_w || (write_collision_flag_r && !(stat_wr_w && !wdata_r[STS_WRITE_COLLISION_FLAG]));
            ovf_r <= (done_w && transfer_done_flag_r) || (ovf_r && !(stat_wr_w && !wdata_r[STS_OVF]));
            role_fault_flag_r <= fault_w || (role_fault_flag_r && !(stat_wr_w && !wdata_r[STS_FAULT]));
            if (stat_wr_w) fault_detect_disable_r <= wdata_r[STS_FDDIS];
        end
    end

    // ---------------------------------------------
    // Master sequencer
    // ---------------------------------------------
    assign m_edge_w = master_act_w && m_st_r == M_SHIFT && tick_w && !lead_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !master_act_w) begin
            m_st_r <= M_IDLE;
            lead_r <= 1'b0;
            pend_r <= 1'b0;
            gap_cnt_r <= 3'h0;
        end else begin
            case (m_st_r)
                M_IDLE: begin
                    if (tick_w && gap_cnt_r != 3'h0) gap_cnt_r <= gap_cnt_r - 3'h1;
                    if (pend_r && gap_cnt_r == 3'h0) begin
                        m_st_r <= M_SHIFT;
                        lead_r <= 1'b1;
                        pend_r <= 1'b0;
                    end
                end
                M_SHIFT: begin
                    if (tick_w) lead_r <= 1'b0;
                    if (m_edge_w && edge_idx_r == LAST_EDGE) begin
                        m_st_r <= M_IDLE;
                        gap_cnt_r <= 3'({1'b0, gap_sel_r} + {2'b00, clock_phase_select_w});
                    end
                end
                default: m_st_r <= M_IDLE;
            endcase
            if (data_acc_w) pend_r <= 1'b1;
        end
    end

    // ---------------------------------------------
    // Shift engine
    // ---------------------------------------------
    assign s_edge_w = slave_sel_w && (sclk_s != sclk_prev_r);
    assign sh_edge_w = role_w ? m_edge_w : s_edge_w;
    assign sample_w = edge_idx_r[0] == clock_phase_select_w;
    assign done_w = sh_edge_w && edge_idx_r == LAST_EDGE;
    assign din_w = role_w ? miso_s : mosi_s;
    assign rx_in_w = lsbf_w ? {din_w, rx_sh_r[7:1]} : {rx_sh_r[6:0], din_w};

    always_comb begin
        tx_nxt = tx_sh_r;
        if (data_acc_w) begin
            tx_nxt = wdata_r;
        end else if (sh_edge_w && !sample_w && edge_idx_r != FIRST_EDGE &&
            edge_idx_r != LAST_EDGE) begin
            tx_nxt = lsbf_w ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
        end
        tx_bit_nxt = lsbf_w ? tx_nxt[0] : tx_nxt[7];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_sh_r <= DATA_RST;
            rx_sh_r <= DATA_RST;
            rx_buf_r <= DATA_RST;
            edge_idx_r <= FIRST_EDGE;
            sclk_prev_r <= 1'b0;
        end else begin
            tx_sh_r <= tx_nxt;
            sclk_prev_r <= sclk_s;
            if (sh_edge_w && sample_w) rx_sh_r <= rx_in_w;
            if (done_w && !transfer_done_flag_r) rx_buf_r <= sample_w ? rx_in_w : rx_sh_r;
            if (!(master_act_w || slave_sel_w)) edge_idx_r <= FIRST_EDGE;
            else if (sh_edge_w) edge_idx_r <= edge_idx_r + 4'h1;
        end
    end

    // ---------------------------------------------
    // Pin drivers and interrupt
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_o <= CTRL_RST[CTL_CLOCK_POLARITY_SELECT];
            sclk_oe_o <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
            ss_n_o <= 1'b1;
            ss_n_oe_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (master_act_w && m_st_r == M_SHIFT) sclk_o <= m_edge_w ? !sclk_o : sclk_o;
            else sclk_o <= clock_polarity_select_w;
            sclk_oe_o <= master_act_w;
            mosi_o <= tx_bit_nxt;
            mosi_oe_o <= master_act_w;
            miso_o <= tx_bit_nxt;
            miso_oe_o <= slave_sel_w;
            ss_n_o <= m_st_r != M_SHIFT;
            ss_n_oe_o <= master_act_w && fault_detect_disable_r && select_output_enable_w;
            irq_o <= irq_en_r[IRQ_BLOCK] && irq_en_r[IRQ_GLOBAL] && (transfer_done_flag_r || ovf_r || role_fault_flag_r);
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    logic [3:0] cyc_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || m_edge_w) cyc_r <= 4'h0;
        else if (cyc_r != 4'hf) cyc_r <= cyc_r + 4'h1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_DIV_HALF: assert property (m_edge_w && edge_idx_r != FIRST_EDGE |->
        cyc_r == 4'((4'h1 << div_w) - 4'h1)) else $error("master half period wrong");
    AST_SLV_NO_CLK: assert property (!role_w |=> !sclk_oe_o)
        else $error("slave drives clock");
    AST_GAP_LOAD: assert property (m_edge_w && edge_idx_r == LAST_EDGE |=>
        gap_cnt_r == ({1'b0, $past(gap_sel_r)} + {2'b00, $past(clock_phase_select_w)}) && m_st_r == M_IDLE)
        else $error("gap not loaded");
    AST_SS_AUTO: assert property (master_act_w && fault_detect_disable_r && select_output_enable_w && m_st_r == M_SHIFT
        |=> ss_n_oe_o && !ss_n_o) else $error("auto select not low");
    AST_FAULT: assert property (fault_w |=> role_fault_flag_r && !role_w && !en_w)
        else $error("fault not handled");
    AST_DONE_TRANSFER_DONE_FLAG: assert property (done_w |=> transfer_done_flag_r)
        else $error("done flag not set");
    AST_TRANSFER_DONE_FLAG_LOCK: assert property (transfer_done_flag_r && wr_data_w && m_st_r == M_IDLE && !pend_r
        |=> !pend_r && $stable(tx_sh_r)) else $error("write taken while done set");
    AST_WRITE_COLLISION_FLAG: assert property (wr_data_w && !transfer_done_flag_r && busy_w |=> write_collision_flag_r)
        else $error("collision not flagged");
    AST_OVF: assert property (done_w && transfer_done_flag_r |=> ovf_r && $stable(rx_buf_r))
        else $error("overrun not flagged");
    AST_IDLE_POL: assert property ((master_act_w && m_st_r == M_IDLE)[*2] |->
        sclk_o == $past(clock_polarity_select_w)) else $error("idle clock level wrong");

    COV_MASTER_BYTE: cover property (role_w && done_w);
    COV_SLAVE_BYTE: cover property (!role_w && done_w);
    COV_FAULT: cover property (fault_w);
    COV_WRITE_COLLISION_FLAG: cover property (write_collision_flag_set_w);
endmodule

// ### testbench/srgd_slave_model.sv
// Far-side SPI slave, clock polarity 0, either phase, MSB first
// Assumes the master's clock, select and data wires are fed in
`timescale 1ns/1ps
module srgd_slave_model (
    // Serial wires
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Format and byte side
    input wire logic clock_phase_select_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    logic [7:0] sh_r;
    logic idle_r;
    int rises;
    initial begin
        sh_r = 8'h00;
        rx_o = 8'h00;
        idle_r = 1'b0;
        rises = 0;
    end
    // Load on select, released line shows inverse of shift register bit 7
    always @(negedge ss_n_i) begin
        sh_r = tx_i;
        rises = 0;
    end
    always @(posedge ss_n_i) idle_r = ~sh_r[7];
    // Phase 0 samples on rises; phase 1 shifts on every rise but the first
    always @(posedge sclk_i) begin
        if (!ss_n_i && !clock_phase_select_i) rx_o = {rx_o[6:0], mosi_i};
        if (!ss_n_i && clock_phase_select_i && rises != 0) sh_r = {sh_r[6:0], 1'b0};
        if (!ss_n_i) rises++;
    end
    always @(negedge sclk_i) begin
        if (!ss_n_i && clock_phase_select_i) rx_o = {rx_o[6:0], mosi_i};
        if (!ss_n_i && !clock_phase_select_i) sh_r = {sh_r[6:0], 1'b0};
    end
    assign miso_o = ss_n_i ? idle_r : sh_r[7];
endmodule

// ### testbench/tb.sv
// Bench of the serial rate, gap and status block
// Assumes the slave model on the far side and a 250 MHz clock
`timescale 1ns/1ps
module tb;
    import srgd_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata_o;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
    logic [1:0] bresp_o, rresp_o;
    logic sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, ss_n_o, ss_n_oe_o;
    logic ext_ss_n = 1, ext_sclk = 0, s_clock_phase_select = 0, sclk_q = 0, m_miso;
    logic [7:0] s_tx = '0, s_rx;
    wire ss_w = ss_n_oe_o ? ss_n_o : ext_ss_n;
    wire sclk_w = sclk_oe_o ? sclk_o : ext_sclk;
    wire mosi_w = mosi_oe_o ? mosi_o : ~s_rx[0];
    wire miso_w = miso_oe_o ? miso_o : m_miso;
    int num_errors = 0, n_tests = 0, seed = 61, edges = 0, run = 0, half_seen = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] tx;
    always #2 ref_clk_i = ~ref_clk_i;
    srgd_top i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready_o), .wdata_i(wdata), .wstrb_i(4'hf),
        .wvalid_i(wvalid), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_o(miso_oe_o), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe_o),
        .irq_o(irq_o));
    srgd_slave_model i_slave (.sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(mosi_w),
        .miso_o(m_miso), .clock_phase_select_i(s_clock_phase_select), .tx_i(s_tx), .rx_o(s_rx));
    // ---------------------------------------------
    // Clock edge monitor
    // ---------------------------------------------
    always @(posedge ref_clk_i) begin
        if (sclk_o !== sclk_q) begin
            edges++;
            half_seen = run;
            run = 1;
        end else begin
            run++;
        end
        sclk_q = sclk_o;
    end
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge ref_clk_i);
            if (awvalid && awready_o === 1) awvalid <= 0;
            if (wvalid && wready_o === 1) wvalid <= 0;
        end while (bvalid_o !== 1);
        r = bresp_o;
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [AXI_AW-1:0] a);
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge ref_clk_i);
            if (arvalid && arready_o === 1) arvalid <= 0;
        end while (rvalid_o !== 1);
        d = rdata_o;
        r = rresp_o;
        rready <= 0;
    endtask
    function automatic int exp_half(input logic [1:0] div);
        return 1 << div;
    endfunction
    task automatic xfer(input logic [1:0] div, input logic ph);
        int t;
        t = 0;
        tx = $random(seed);
        s_tx = $random(seed);
        s_clock_phase_select = ph;
        axi_wr(ADDR_IRQ_EN, {30'h0, div != 2'h0, 1'b1});
        axi_wr(ADDR_CTRL, {24'h0, 8'hd0 | {5'h00, ph, div}});
        edges = 0;
        axi_wr(ADDR_DATA, {24'h0, tx});
        do begin
            axi_rd(ADDR_STATUS);
            t++;
        end while (d[STS_DONE] !== 1 && t < 200);
        chk("done", 1, d[STS_DONE]);
        chk("edges", 16, edges);
        chk("half", exp_half(div), half_seen);
        chk("irq", div != 2'h0, irq_o);
        axi_wr(ADDR_DATA, 32'h0000005a);
        repeat (40) @(posedge ref_clk_i);
        chk("ignored", 16, edges);
        axi_rd(ADDR_DATA);
        if (div[1]) chk("rx", s_tx, d);
        chk("slave_rx", tx, s_rx);
        axi_wr(ADDR_STATUS, 32'h00000008);
        axi_rd(ADDR_STATUS);
        chk("cleared", 32'h08, d);
    endtask
    task automatic complete_run;
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        chk("ss_oe", 0, ss_n_oe_o);
        axi_rd(ADDR_GAP_CTRL);
        chk("gap_rst", GAP_CTRL_RST, d);
        axi_rd(ADDR_STATUS);
        chk("sts_rst", STATUS_RST, d);
        axi_rd(ADDR_DATA);
        chk("data_rst", DATA_RST, d);
        axi_wr(ADDR_GAP_CTRL, 32'h000000ff);
        chk("bresp", RESP_OKAY, r);
        axi_rd(ADDR_GAP_CTRL);
        chk("gap_rsv", 32'h03, d);
        axi_rd(12'h000);
        chk("unmapped", RESP_SLVERR, r);
        axi_wr(ADDR_STATUS, 32'h00000008);
        for (int k = 0; k < 4; k++) xfer(k[1:0], 1'b0);
        xfer(2'h2, 1'b1);
        axi_wr(ADDR_CTRL, 32'h000000db);
        repeat (8) @(posedge ref_clk_i);
        chk("idle_hi", 1, sclk_o);
        // Fault: select pulled low while fault detection is on
        axi_wr(ADDR_CTRL, 32'h00000053);
        axi_wr(ADDR_STATUS, 32'h00000000);
        ext_ss_n <= 0;
        repeat (6) @(posedge ref_clk_i);
        axi_rd(ADDR_STATUS);
        chk("fault", 1, d[STS_FAULT]);
        axi_rd(ADDR_CTRL);
        chk("ctrl_fault", 32'h03, d);
        chk("irq_fault", 1, irq_o);
        // Slave: select low then a data write collides
        axi_wr(ADDR_STATUS, 32'h00000000);
        axi_wr(ADDR_CTRL, 32'h00000040);
        repeat (6) @(posedge ref_clk_i);
        chk("slave_oe", 0, sclk_oe_o);
        chk("slave_miso_oe", 1, miso_oe_o);
        axi_wr(ADDR_DATA, 32'h000000c3);
        axi_rd(ADDR_STATUS);
        chk("write_collision_flag", 1, d[STS_WRITE_COLLISION_FLAG]);
        axi_rd(ADDR_STATUS);
        chk("write_collision_flag_held", 1, d[STS_WRITE_COLLISION_FLAG]);
        // Two slave bytes clocked in without clearing done: overrun
        repeat (32) begin
            repeat (4) @(posedge ref_clk_i);
            ext_sclk <= ~ext_sclk;
        end
        repeat (4) @(posedge ref_clk_i);
        axi_rd(ADDR_STATUS);
        chk("slave_done", 1, d[STS_DONE]);
        chk("overrun", 1, d[STS_OVF]);
        ext_ss_n <= 1;
        complete_run();
    end
endmodule
